// ### hdl/gcfg_defs.svh
/*
 Offsets, field positions, reset values and timing figures of the gyro
 configuration register block. Assumes a 250 MHz core clock.
*/
`ifndef GCFG_DEFS_SVH
`define GCFG_DEFS_SVH

`define GCFG_ADDR_W 7
`define GCFG_OFS_RATE_DIV 7'h19
`define GCFG_OFS_SYNC_FILTER 7'h1a
`define GCFG_OFS_RANGE_CFG 7'h1b
`define GCFG_OFS_QUEUE_SEL 7'h23
`define GCFG_OFS_PIN_CFG 7'h37
`define GCFG_OFS_IRQ_EN 7'h38
`define GCFG_OFS_IRQ_STATUS 7'h3a
`define GCFG_OFS_DATA_FIRST 7'h41
`define GCFG_OFS_DATA_LAST 7'h48
`define GCFG_OFS_USER_CTRL 7'h6a
`define GCFG_OFS_QCOUNT_H 7'h72
`define GCFG_OFS_QCOUNT_L 7'h73
`define GCFG_OFS_QDATA 7'h74

`define GCFG_BIT_OVERFLOW 4
`define GCFG_BIT_SYNC 3
`define GCFG_BIT_READY 0
`define GCFG_BIT_USER_QUEUE 6
`define GCFG_IRQ_MASK 8'h19

`define GCFG_RESET_BYTE 8'h00

`define GCFG_CLK_PS 4000
`define GCFG_PULSE_US 50
`define GCFG_RATE_32K_HZ 32000
`define GCFG_RATE_8K_HZ 8000
`define GCFG_RATE_1K_HZ 1000

`endif

// ### hdl/gcfg_pkg.sv
/*
 Types of the gyro configuration register block.
 Assumes gcfg_defs.svh is on the include path.
*/
package gcfg_pkg;

   typedef struct packed {
      logic overflow_keep;
      logic [2:0] sync_sample_select;
      logic [2:0] lowpass_setting;
   } gcfg_sync_cfg_t;

   typedef struct packed {
      logic [2:0] selftest;
      logic [1:0] range_select;
      logic [1:0] filter_bypass_choice;
   } gcfg_range_cfg_t;

   typedef struct packed {
      logic irq_active_low;
      logic irq_open_drain;
      logic irq_latch;
      logic any_read_clear;
      logic sync_irq_polarity;
      logic sync_irq_mode;
   } gcfg_pin_cfg_t;

   typedef struct packed {
      logic [15:0] temp;
      logic [15:0] x;
      logic [15:0] y;
      logic [15:0] z;
   } gcfg_sample_t;

   typedef enum logic [2:0] {
      GCFG_RATE_32K = 3'b001,
      GCFG_RATE_8K = 3'b010,
      GCFG_RATE_DIV = 3'b100
   } gcfg_rate_mode_t;

   typedef enum logic [1:0] {
      GCFG_LD_IDLE = 2'b01,
      GCFG_LD_RUN = 2'b10
   } gcfg_load_state_t;

endpackage : gcfg_pkg

// ### hdl/gcfg_regs.sv
/*
 Gyro configuration registers: sample-rate timing, sensor data capture,
 byte queue with overflow policy, interrupt status and interrupt pin.
 Assumes a synchronous sensor front end presenting raw samples, and a
 host register port with one-cycle strobes and read data a cycle later.
*/
// Our own choice: the plain strobed port.
`timescale 1ns/1ps
`include "gcfg_defs.svh"

module gcfg_regs
   import gcfg_pkg::*;
#(
   parameter int unsigned QUEUE_DEPTH = 64,
   parameter int unsigned PULSE_CYC = (`GCFG_PULSE_US * 1000000) / `GCFG_CLK_PS,
   parameter int unsigned PERIOD_32K_CYC = 1000000000 / (`GCFG_RATE_32K_HZ * 4),
   parameter int unsigned PERIOD_8K_CYC = 1000000000 / (`GCFG_RATE_8K_HZ * 4),
   parameter int unsigned PERIOD_1K_CYC = 1000000000 / (`GCFG_RATE_1K_HZ * 4)
)
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic sys_rst,
   // Register port
   input wire logic [`GCFG_ADDR_W-1:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // Sensor front end
   input wire gcfg_sample_t sample_in,
   input wire logic frame_sync_pin,
   output logic sample_tick,
   output logic [2:0] selftest_axes,
   output logic [1:0] range_select,
   output logic [10:0] range_dps,
   output logic [2:0] lowpass_setting,
   output logic [1:0] filter_bypass_choice,
   // Interrupt pin
   output logic irq_pin_out,
   output logic irq_pin_oe
);

   localparam int QW = $clog2(QUEUE_DEPTH);

   gcfg_sync_cfg_t sync_cfg_reg;
   gcfg_range_cfg_t range_cfg_reg;
   gcfg_pin_cfg_t pin_cfg_reg;
   logic [7:0] rate_divider_reg;
   logic [3:0] queue_sel_reg;
   logic [7:0] irq_en_reg;
   logic [7:0] irq_status_reg;
   logic [7:0] irq_status_next;
   logic user_queue_en_reg;
   logic [7:0] rdata_reg;

   // Configuration writes; reserved bits are simply not stored
   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         sync_cfg_reg <= '0;
         range_cfg_reg <= '0;
         pin_cfg_reg <= '0;
         rate_divider_reg <= `GCFG_RESET_BYTE;
         queue_sel_reg <= '0;
         irq_en_reg <= `GCFG_RESET_BYTE;
         user_queue_en_reg <= 1'b0;
      end
      else if (reg_wr)
      begin
         case (reg_addr)
            `GCFG_OFS_RATE_DIV: rate_divider_reg <= reg_wdata;
            `GCFG_OFS_SYNC_FILTER: sync_cfg_reg <= reg_wdata[6:0];
            `GCFG_OFS_RANGE_CFG:
            begin
               range_cfg_reg.selftest <= reg_wdata[7:5];
               range_cfg_reg.range_select <= reg_wdata[4:3];
               range_cfg_reg.filter_bypass_choice <= reg_wdata[1:0];
            end
            `GCFG_OFS_QUEUE_SEL: queue_sel_reg <= reg_wdata[7:4];
            `GCFG_OFS_PIN_CFG: pin_cfg_reg <= reg_wdata[7:2];
            `GCFG_OFS_IRQ_EN: irq_en_reg <= reg_wdata & `GCFG_IRQ_MASK;
            `GCFG_OFS_USER_CTRL: user_queue_en_reg <= reg_wdata[`GCFG_BIT_USER_QUEUE];
            default: ;
         endcase
      end
   end

   // Front-end controls
   assign selftest_axes = range_cfg_reg.selftest;
   assign range_select = range_cfg_reg.range_select;
   assign lowpass_setting = sync_cfg_reg.lowpass_setting;
   assign filter_bypass_choice = range_cfg_reg.filter_bypass_choice;

   always_comb
   begin
      case (range_cfg_reg.range_select)
         2'd0: range_dps = 11'd250;
         2'd1: range_dps = 11'd500;
         2'd2: range_dps = 11'd1000;
         default: range_dps = 11'd2000;
      endcase
   end

   // Sample rate selection
   gcfg_rate_mode_t rate_mode;
   always_comb
   begin
      if (range_cfg_reg.filter_bypass_choice != 2'b00)
         rate_mode = GCFG_RATE_32K;
      else if (sync_cfg_reg.lowpass_setting == 3'd0 || sync_cfg_reg.lowpass_setting == 3'd7)
         rate_mode = GCFG_RATE_8K;
      else
         rate_mode = GCFG_RATE_DIV;
   end

   localparam logic [17:0] LAST_32K = 18'(PERIOD_32K_CYC - 1);
   localparam logic [17:0] LAST_8K = 18'(PERIOD_8K_CYC - 1);
   localparam logic [17:0] LAST_1K = 18'(PERIOD_1K_CYC - 1);

   logic [17:0] base_cnt_reg;
   logic [17:0] base_last;
   logic base_wrap;
   logic [7:0] div_cnt_reg;
   logic tick;

   always_comb
   begin
      case (rate_mode)
         GCFG_RATE_32K: base_last = LAST_32K;
         GCFG_RATE_8K: base_last = LAST_8K;
         GCFG_RATE_DIV: base_last = LAST_1K;
         default: base_last = LAST_1K;
      endcase
   end

   assign base_wrap = (base_cnt_reg >= base_last);
   // Divider only takes effect in the 1 kHz mode
   assign tick = base_wrap && (rate_mode != GCFG_RATE_DIV || div_cnt_reg >= rate_divider_reg);

   always_ff @(posedge core_clk)
   begin
      if (sys_rst || base_wrap)
         base_cnt_reg <= '0;
      else
         base_cnt_reg <= base_cnt_reg + 18'd1;
   end

   always_ff @(posedge core_clk)
   begin
      if (sys_rst || tick)
         div_cnt_reg <= '0;
      else if (base_wrap)
         div_cnt_reg <= div_cnt_reg + 8'd1;
   end

   logic tick_reg;
   always_ff @(posedge core_clk)
   begin
      tick_reg <= !sys_rst && tick;
   end
   assign sample_tick = tick_reg;

   // Sync pin: latched so short strobes survive until the next sample
   logic sync_latch_reg;
   logic sync_prev_reg;
   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
         sync_latch_reg <= 1'b0;
      else if (tick)
         sync_latch_reg <= frame_sync_pin;
      else if (frame_sync_pin)
         sync_latch_reg <= 1'b1;
   end

   // Sensor data registers, self-test response included
   gcfg_sample_t data_reg;
   gcfg_sample_t data_next;
   logic sync_bit;
   assign sync_bit = sync_latch_reg | frame_sync_pin;
   always_comb
   begin
      data_next = sample_in;
      case (sync_cfg_reg.sync_sample_select)
         3'd1: data_next.temp[0] = sync_bit;
         3'd2: data_next.x[0] = sync_bit;
         3'd3: data_next.y[0] = sync_bit;
         3'd4: data_next.z[0] = sync_bit;
         default: ;
      endcase
   end

   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
         data_reg <= '0;
      else if (tick)
         data_reg <= data_next;
   end

   // Queue loader walks the eight data bytes after each sample
   gcfg_load_state_t ld_state_reg;
   logic [2:0] ld_idx_reg;
   logic [7:0] ld_byte;
   logic ld_en;
   logic [63:0] data_flat;
   assign data_flat = data_reg;
   assign ld_byte = data_flat[8'(63 - 8 * ld_idx_reg) -: 8];
   assign ld_en = (ld_state_reg == GCFG_LD_RUN) && queue_sel_reg[2'(3 - ld_idx_reg[2:1])];

   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         ld_state_reg <= GCFG_LD_IDLE;
         ld_idx_reg <= '0;
      end
      else
      begin
         case (ld_state_reg)
            GCFG_LD_IDLE:
            begin
               ld_idx_reg <= '0;
               if (tick_reg)
                  ld_state_reg <= GCFG_LD_RUN;
            end
            GCFG_LD_RUN:
            begin
               ld_idx_reg <= ld_idx_reg + 3'd1;
               if (ld_idx_reg == 3'd7)
                  ld_state_reg <= GCFG_LD_IDLE;
            end
            default: ld_state_reg <= GCFG_LD_IDLE;
         endcase
      end
   end

   // Byte queue
   logic [7:0] queue_mem [QUEUE_DEPTH];
   logic [QW-1:0] wr_ptr_reg;
   logic [QW-1:0] rd_ptr_reg;
   logic [QW:0] count_reg;
   logic full;
   logic empty;
   logic q_push;
   logic q_pop;
   logic q_drop_old;
   logic overflow_ev;

   assign full = (count_reg == (QW+1)'(QUEUE_DEPTH));
   assign empty = (count_reg == '0);
   assign q_pop = reg_rd && reg_addr == `GCFG_OFS_QDATA && user_queue_en_reg && !empty;
   assign q_push = ld_en && !(full && sync_cfg_reg.overflow_keep);
   assign q_drop_old = q_push && full && !q_pop;
   assign overflow_ev = ld_en && full && !q_pop;

   always_ff @(posedge core_clk)
   begin
      if (q_push)
         queue_mem[wr_ptr_reg] <= ld_byte;
   end

   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
         wr_ptr_reg <= '0;
      else if (q_push)
         wr_ptr_reg <= (wr_ptr_reg == QW'(QUEUE_DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
   end

   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
         rd_ptr_reg <= '0;
      else if (q_pop || q_drop_old)
         rd_ptr_reg <= (rd_ptr_reg == QW'(QUEUE_DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
   end

   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
         count_reg <= '0;
      else if (q_push && !q_pop && !full)
         count_reg <= count_reg + 1'b1;
      else if (q_pop && !q_push)
         count_reg <= count_reg - 1'b1;
   end

   // Interrupt status; a set in the clearing cycle survives
   logic sync_active;
   logic sync_ev;
   logic status_clr;
   logic [7:0] events;
   assign sync_active = frame_sync_pin ^ pin_cfg_reg.sync_irq_polarity;

   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
         sync_prev_reg <= 1'b0;
      else
         sync_prev_reg <= sync_active;
   end

   assign sync_ev = pin_cfg_reg.sync_irq_mode && sync_active && !sync_prev_reg;
   assign status_clr = reg_rd && (reg_addr == `GCFG_OFS_IRQ_STATUS || pin_cfg_reg.any_read_clear);

   always_comb
   begin
      events = '0;
      events[`GCFG_BIT_OVERFLOW] = overflow_ev;
      events[`GCFG_BIT_SYNC] = sync_ev;
      events[`GCFG_BIT_READY] = tick_reg;
      irq_status_next = (status_clr ? 8'h00 : irq_status_reg) | events;
   end

   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
         irq_status_reg <= `GCFG_RESET_BYTE;
      else
         irq_status_reg <= irq_status_next;
   end

   // Interrupt pin
   logic [7:0] new_enabled;
   localparam int PW = $clog2(PULSE_CYC + 1);
   logic [PW-1:0] pulse_cnt_reg;
   logic irq_asserted;
   logic pin_level;
   assign new_enabled = events & irq_en_reg;

   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
         pulse_cnt_reg <= '0;
      else if (|new_enabled)
         pulse_cnt_reg <= PW'(PULSE_CYC);
      else if (pulse_cnt_reg != '0)
         pulse_cnt_reg <= pulse_cnt_reg - 1'b1;
   end

   assign irq_asserted = pin_cfg_reg.irq_latch ? |(irq_status_reg & irq_en_reg)
                                               : (pulse_cnt_reg != '0);
   assign pin_level = irq_asserted ^ pin_cfg_reg.irq_active_low;

   always_comb
   begin
      if (pin_cfg_reg.irq_open_drain)
      begin
         irq_pin_out = 1'b0;
         irq_pin_oe = !pin_level;
      end
      else
      begin
         irq_pin_out = pin_level;
         irq_pin_oe = 1'b1;
      end
   end

   // Read port; unmapped addresses read zero
   logic [3:0] data_ofs;
   assign data_ofs = 4'(reg_addr - `GCFG_OFS_DATA_FIRST);

   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
         rdata_reg <= '0;
      else if (reg_rd)
      begin
         case (reg_addr)
            `GCFG_OFS_RATE_DIV: rdata_reg <= rate_divider_reg;
            `GCFG_OFS_SYNC_FILTER: rdata_reg <= {1'b0, sync_cfg_reg};
            `GCFG_OFS_RANGE_CFG:
               rdata_reg <= {range_cfg_reg.selftest, range_cfg_reg.range_select, 1'b0,
                             range_cfg_reg.filter_bypass_choice};
            `GCFG_OFS_QUEUE_SEL: rdata_reg <= {queue_sel_reg, 4'h0};
            `GCFG_OFS_PIN_CFG: rdata_reg <= {pin_cfg_reg, 2'b00};
            `GCFG_OFS_IRQ_EN: rdata_reg <= irq_en_reg;
            `GCFG_OFS_IRQ_STATUS: rdata_reg <= irq_status_reg;
            `GCFG_OFS_USER_CTRL: rdata_reg <= 8'(user_queue_en_reg) << `GCFG_BIT_USER_QUEUE;
            `GCFG_OFS_QCOUNT_H: rdata_reg <= 8'(count_reg >> 8);
            `GCFG_OFS_QCOUNT_L: rdata_reg <= 8'(count_reg);
            `GCFG_OFS_QDATA: rdata_reg <= q_pop ? queue_mem[rd_ptr_reg] : 8'h00;
            default:
            begin
               if (reg_addr >= `GCFG_OFS_DATA_FIRST && reg_addr <= `GCFG_OFS_DATA_LAST)
                  rdata_reg <= data_flat[8'(63 - 8 * data_ofs[2:0]) -: 8];
               else
                  rdata_reg <= 8'h00;
            end
         endcase
      end
      else
         rdata_reg <= 8'h00;
   end

   assign reg_rdata = rdata_reg;

endmodule : gcfg_regs

// ### tb/gcfg_monitor.sv
/*
 Port checker for gcfg_regs, attached by bind.
 Assumes one-cycle register strobes and shadows the rate divider, sync, range and pin config writes.
*/
`timescale 1ns/1ps
`include "gcfg_defs.svh"
module gcfg_monitor
   import gcfg_pkg::*;
#(
   parameter int unsigned PULSE_CYC = 12500,
   parameter int unsigned PERIOD_32K_CYC = 7812,
   parameter int unsigned PERIOD_8K_CYC = 31250,
   parameter int unsigned PERIOD_1K_CYC = 250000
)
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic sys_rst,
   // Register port
   input wire logic [`GCFG_ADDR_W-1:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   // Sensor side
   input wire logic sample_tick,
   input wire logic [2:0] selftest_axes,
   input wire logic [1:0] range_select,
   input wire logic [10:0] range_dps,
   input wire logic [2:0] lowpass_setting,
   input wire logic [1:0] filter_bypass_choice,
   // Interrupt pin
   input wire logic irq_pin_out,
   input wire logic irq_pin_oe
);
   logic [7:0] div_reg, cfg_reg, rng_reg, pin_reg;
   logic [31:0] gap_reg, hi_reg, want;
   logic [1:0] dirty_reg;

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (sys_rst);

   always_ff @(posedge core_clk)
      if (sys_rst)
      begin
         div_reg <= 8'h00;
         cfg_reg <= 8'h00;
         rng_reg <= 8'h00;
         pin_reg <= 8'h00;
      end
      else if (reg_wr)
         case (reg_addr)
            7'h19: div_reg <= reg_wdata;
            7'h1a: cfg_reg <= reg_wdata;
            7'h1b: rng_reg <= reg_wdata;
            7'h37: pin_reg <= reg_wdata;
            default: ;
         endcase

   always_comb
      if (rng_reg[1:0] != 2'h0)
         want = PERIOD_32K_CYC;
      else if (cfg_reg[2:0] == 3'h0 || cfg_reg[2:0] == 3'h7)
         want = PERIOD_8K_CYC;
      else
         want = PERIOD_1K_CYC * (div_reg + 1);

   // Two ticks after a rate write may straddle the old and new period
   always_ff @(posedge core_clk)
      if (sys_rst || reg_wr && reg_addr inside {7'h19, 7'h1a, 7'h1b})
         dirty_reg <= 2'h2;
      else if (sample_tick && dirty_reg != 2'h0)
         dirty_reg <= dirty_reg - 2'h1;

   always_ff @(posedge core_clk)
      gap_reg <= (sys_rst || sample_tick) ? 32'h0 : gap_reg + 1;

   always_ff @(posedge core_clk)
      hi_reg <= (sys_rst || !irq_pin_out) ? 32'h0 : hi_reg + 1;

   a_tick_single: assert property (sample_tick |=> !sample_tick)
      else $error("tick wider than one cycle");
   a_tick_spacing: assert property (sample_tick && dirty_reg == 2'h0 |-> gap_reg == want - 1)
      else $error("sample period wrong");
   a_pulse_width: assert property ($fell(irq_pin_out) && $stable(pin_reg) && pin_reg[7:5] == 3'h0
      |-> hi_reg == PULSE_CYC)
      else $error("pulse width wrong");
   a_range_map: assert property (range_select == rng_reg[4:3]
      && range_dps == (11'h0fa << rng_reg[4:3]))
      else $error("range mapping wrong");
   a_cfg_fields: assert property (selftest_axes == rng_reg[7:5]
      && filter_bypass_choice == rng_reg[1:0] && lowpass_setting == cfg_reg[2:0])
      else $error("config field outputs wrong");
   a_push_pull: assert property (!pin_reg[6] |-> irq_pin_oe)
      else $error("push-pull pin not driven");
   a_open_drain: assert property (pin_reg[6] |-> !irq_pin_out)
      else $error("open-drain pin drives high");
   a_sync_readback: assert property (reg_rd && reg_addr == 7'h1a
      |=> reg_rdata == {1'b0, cfg_reg[6:0]})
      else $error("sync config readback wrong");
   a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
      else $error("read data outside read cycle");
endmodule : gcfg_monitor

bind gcfg_regs gcfg_monitor #(
   .PULSE_CYC(PULSE_CYC),
   .PERIOD_32K_CYC(PERIOD_32K_CYC),
   .PERIOD_8K_CYC(PERIOD_8K_CYC),
   .PERIOD_1K_CYC(PERIOD_1K_CYC)
) i_gcfg_monitor (.core_clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
   .sample_tick, .selftest_axes, .range_select, .range_dps, .lowpass_setting,
   .filter_bypass_choice, .irq_pin_out, .irq_pin_oe);

// ### tb/gcfg_front.sv
/*
 Sensor front end model: raw samples that step once per sample tick.
 Assumes sample_tick and selftest_axes come from gcfg_regs.
*/
`timescale 1ns/1ps
module gcfg_front
   import gcfg_pkg::*;
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic sys_rst,
   // From the block
   input wire logic sample_tick,
   input wire logic [2:0] selftest_axes,
   // Raw data
   output gcfg_sample_t sample_in,
   output logic [7:0] seq
);
   // Fresh values each period so a stale capture shows up
   always_ff @(posedge core_clk)
      seq <= sys_rst ? 8'h00 : seq + 8'(sample_tick);

   always_comb
   begin
      sample_in.temp = 16'h7000 + seq;
      sample_in.x = 16'h1000 + seq + {selftest_axes[2], 10'h000};
      sample_in.y = 16'h2000 + seq + {selftest_axes[1], 10'h000};
      sample_in.z = 16'h3000 + seq + {selftest_axes[0], 10'h000};
   end
endmodule : gcfg_front

// ### tb/gcfg_regs_test.sv
/*
 Self-checking bench for gcfg_regs with a sensor front end model.
 Assumes shortened timing parameters and a 250 MHz clock.
*/
`timescale 1ns/1ps
module gcfg_regs_test
   import gcfg_pkg::*;
;
   logic core_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic [6:0] reg_addr = 7'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic frame_sync_pin = 1'b0;
   logic [7:0] reg_rdata, seq, d, h;
   gcfg_sample_t sample_in;
   logic sample_tick, irq_pin_out, irq_pin_oe;
   logic [2:0] selftest_axes, lowpass_setting;
   logic [1:0] range_select, filter_bypass_choice;
   logic [10:0] range_dps;
   int failures = 0;
   int tests_run = 0;
   logic [6:0] ofs [4] = '{7'h1a, 7'h1b, 7'h23, 7'h37};
   logic [7:0] msk [4] = '{8'h7f, 8'hfb, 8'hf0, 8'hfc};
   // {range cfg, sync cfg, divider, period}
   logic [31:0] rt [4] = '{32'h0000_0028, 32'h0007_0228, 32'h0003_0164, 32'h0203_0114};

   always #2 core_clk = ~core_clk;

   gcfg_regs #(.QUEUE_DEPTH(4), .PULSE_CYC(20), .PERIOD_32K_CYC(20), .PERIOD_8K_CYC(40),
      .PERIOD_1K_CYC(50)) i_gcfg_regs (.core_clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr,
      .reg_rd, .reg_rdata, .sample_in, .frame_sync_pin, .sample_tick, .selftest_axes,
      .range_select, .range_dps, .lowpass_setting, .filter_bypass_choice, .irq_pin_out,
      .irq_pin_oe);
   gcfg_front i_gcfg_front (.core_clk, .sys_rst, .sample_tick, .selftest_axes, .sample_in,
      .seq);

   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
      tests_run++;
      if (s !== e)
      begin
         failures++;
         $display("ERROR %s expected %h seen %h", n, e, s);
      end
   endtask : chk

   task automatic wr(input logic [6:0] a, input logic [7:0] v);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
      #1;
   endtask : wr

   task automatic rd(input logic [6:0] a);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1;
      d = reg_rdata;
   endtask : rd

   task automatic wt(output int n);
      n = 0;
      do
      begin
         @(posedge core_clk);
         #1;
         n++;
      end
      while (sample_tick !== 1'b1 && n < 900);
      chk("tick", n < 900, 1'b1);
   endtask : wt

   task automatic sy(input logic v);
      @(posedge core_clk);
      frame_sync_pin <= v;
      repeat (3) @(posedge core_clk);
      #1;
   endtask : sy

   task automatic t_regs;
      foreach (ofs[i])
      begin
         rd(ofs[i]);
         chk("reset", d, 8'h00);
         wr(ofs[i], 8'hff);
         rd(ofs[i]);
         chk("readback", d, msk[i]);
         wr(ofs[i], 8'h00);
      end
      rd(7'h7f);
      chk("unmapped", d, 8'h00);
   endtask : t_regs

   task automatic t_range;
      int n;
      for (int c = 0; c < 4; c++)
      begin
         wr(7'h1b, {3'h5, c[1:0], 3'h1});
         chk("dps", range_dps, 11'h0fa << c);
         chk("range", range_select, c);
         chk("axes", selftest_axes, 3'h5);
         chk("bypass", filter_bypass_choice, 2'h1);
      end
      wr(7'h1a, 8'h05);
      chk("lowpass", lowpass_setting, 3'h5);
      wt(n);
      n = 16'h1400 + seq;
      rd(7'h43);
      h = d;
      rd(7'h44);
      chk("xout", {h, d}, n);
      wr(7'h1a, 8'h15);
      sy(1'b1);
      wt(n);
      n = (16'h1400 + seq) | 1;
      rd(7'h44);
      chk("sync lsb", d, n[7:0]);
      sy(1'b0);
   endtask : t_range

   task automatic t_rate;
      int n;
      foreach (rt[i])
      begin
         wr(7'h19, rt[i][15:8]);
         wr(7'h1a, rt[i][23:16]);
         wr(7'h1b, rt[i][31:24]);
         repeat (3) wt(n);
         chk("period", n, rt[i][7:0]);
      end
   endtask : t_rate

   task automatic t_queue(input logic keep);
      int n;
      logic [15:0] e [3];
      wr(7'h1a, {1'b0, keep, 6'h00});
      wr(7'h6a, 8'h40);
      repeat (6) rd(7'h74);
      wr(7'h6a, 8'h00);
      rd(7'h3a);
      wt(n);
      // Enable only after this sample's loader has passed the x bytes
      repeat (10) @(posedge core_clk);
      wr(7'h23, 8'h40);
      foreach (e[i])
      begin
         wt(n);
         e[i] = 16'h1000 + seq;
      end
      repeat (12) @(posedge core_clk);
      wr(7'h23, 8'h00);
      rd(7'h74);
      chk("gated", d, 8'h00);
      rd(7'h73);
      chk("count", d, 8'h04);
      rd(7'h3a);
      chk("overflow", d[4], 1'b1);
      wr(7'h6a, 8'h40);
      for (int i = 0; i < 2; i++)
      begin
         rd(7'h74);
         chk("q hi", d, e[i + !keep][15:8]);
         rd(7'h74);
         chk("q lo", d, e[i + !keep][7:0]);
      end
   endtask : t_queue

   task automatic t_sync;
      int n;
      wr(7'h38, 8'h08);
      wr(7'h37, 8'h24);
      rd(7'h3a);
      sy(1'b1);
      chk("latched", irq_pin_out, 1'b1);
      rd(7'h1a);
      chk("kept", irq_pin_out, 1'b1);
      rd(7'h3a);
      chk("flag", d[3], 1'b1);
      chk("cleared", irq_pin_out, 1'b0);
      wr(7'h37, 8'h2c);
      sy(1'b0);
      chk("low sync", irq_pin_out, 1'b1);
      rd(7'h3a);
      chk("low flag", d[3], 1'b1);
      wr(7'h37, 8'h20);
      sy(1'b1);
      sy(1'b0);
      rd(7'h3a);
      chk("mode off", d[3], 1'b0);
      wr(7'h38, 8'h00);
      wr(7'h37, 8'h24);
      sy(1'b1);
      chk("masked", irq_pin_out, 1'b0);
      rd(7'h3a);
      chk("masked flag", d[3], 1'b1);
      wr(7'h38, 8'h08);
      wr(7'h37, 8'h34);
      sy(1'b0);
      sy(1'b1);
      rd(7'h1a);
      rd(7'h3a);
      chk("any read", d[3], 1'b0);
      wr(7'h37, 8'ha4);
      chk("idle low", irq_pin_out, 1'b1);
      sy(1'b0);
      sy(1'b1);
      chk("act low", irq_pin_out, 1'b0);
      wr(7'h37, 8'he4);
      chk("od drive", irq_pin_oe, 1'b1);
      rd(7'h3a);
      chk("od float", irq_pin_oe, 1'b0);
      // Old pulse must run out before pulse mode is watched
      repeat (20) @(posedge core_clk);
      wr(7'h37, 8'h04);
      sy(1'b0);
      @(posedge core_clk);
      frame_sync_pin <= 1'b1;
      n = 0;
      while (irq_pin_out !== 1'b1 && n < 10)
      begin
         @(posedge core_clk);
         #1;
         n++;
      end
      n = 0;
      while (irq_pin_out === 1'b1 && n < 99)
      begin
         @(posedge core_clk);
         #1;
         n++;
      end
      chk("pulse", n, 20);
   endtask : t_sync

   task automatic close_out;
      $display("Checks %0d, failures %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : close_out

   initial
   begin
      repeat (5) @(posedge core_clk);
      sys_rst <= 1'b0;
      t_regs;
      t_range;
      t_rate;
      t_queue(1'b1);
      t_queue(1'b0);
      t_sync;
      close_out;
   end

   // Whole run needs somewhat more than a thousand cycles
   initial
   begin
      repeat (20000) @(posedge core_clk);
      failures++;
      close_out;
   end
endmodule : gcfg_regs_test
